// File: rtl/dbg_defines.svh
// Offsets, field positions, capability masks and reset values of the event sequencer
`ifndef DBG_DEFINES_SVH
`define DBG_DEFINES_SVH

// ****************************************
// Sizes
// ****************************************
`define DBG_CH_NUM 12
`define DBG_STAGE_MAX 8
`define DBG_ADDR_W 12

// ****************************************
// Register map
// ****************************************
`define DBG_W_CTRL 2'h0
`define DBG_W_ADDR 2'h1
`define DBG_W_DATA 2'h2
`define DBG_W_AUX 2'h3
`define DBG_GLOBAL_IDX 4'hc
`define DBG_W_SEQ 2'h0
`define DBG_W_STATUS 2'h1
`define DBG_W_SWTR 2'h2

// ****************************************
// Control word fields
// ****************************************
`define DBG_F_EN 0
`define DBG_F_ADDR 1
`define DBG_F_DATA 2
`define DBG_F_ASID 3
`define DBG_F_BUS 4
`define DBG_F_WIN 5
`define DBG_F_SYS 6
`define DBG_F_TLB 7
`define DBG_F_CNT 8
`define DBG_F_BR 9
`define DBG_F_ACT_B 10
`define DBG_F_ACT_T 11
`define DBG_F_ACT_PS 12
`define DBG_F_ACT_PE 13
`define DBG_F_RW 14

// ****************************************
// Capability masks per channel
// ****************************************
`define DBG_CAP_CH1 16'h741b
`define DBG_CAP_CH2 16'h751f
`define DBG_CAP_CH3 16'h340b
`define DBG_CAP_CH4 16'h340b
`define DBG_CAP_CH5 16'h7c39
`define DBG_CAP_CH6 16'h7c39
`define DBG_CAP_CH7 16'h0481
`define DBG_CAP_CH8 16'h3c43
`define DBG_CAP_CH9 16'h3c43
`define DBG_CAP_CH10 16'h741b
`define DBG_CAP_CH11 16'h751f
`define DBG_CAP_CH12 16'h3e01
`define DBG_FIX_CH7 16'h0400

// ****************************************
// Reset values
// ****************************************
`define DBG_RST_CTRL 16'h0000
`define DBG_RST_WORD 32'h0000_0000

`endif

// File: rtl/dbg_pkg.sv
// Types shared by the event sequencer modules
package dbg_pkg;

  typedef enum logic [3:0] {
    SEQ_NONE = 4'h0,
    SEQ_2_1 = 4'h1,
    SEQ_4_3 = 4'h2,
    SEQ_6_5 = 4'h3,
    SEQ_11_10 = 4'h4,
    SEQ_3_1 = 4'h5,
    SEQ_4_1 = 4'h6,
    SEQ_5_1 = 4'h7,
    SEQ_6_1 = 4'h8,
    SEQ_10_1 = 4'h9,
    SEQ_11_1 = 4'ha
  } seq_mode_t;

  typedef enum logic {
    SEQ_IDLE = 1'b0,
    SEQ_WAIT = 1'b1
  } seq_state_t;

endpackage : dbg_pkg

// File: rtl/event_channel.sv
// One event-match channel with its match counter
`timescale 1ns/100ps
`include "dbg_defines.svh"
module event_channel import dbg_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic clr_cnt,
  input wire logic [15:0] ctrl,
  input wire logic [31:0] match_addr,
  input wire logic [31:0] match_data,
  input wire logic [31:0] match_aux,
  input wire logic core_bus_valid,
  input wire logic core_write,
  input wire logic [31:0] core_addr,
  input wire logic [31:0] core_data,
  input wire logic core_pc_valid,
  input wire logic [31:0] core_pc,
  input wire logic [7:0] core_asid,
  input wire logic sys_valid,
  input wire logic [31:0] sys_addr,
  input wire logic tlb_entry_load_instruction,
  input wire logic core_branch,
  output logic hit
);

  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic [9:1] ok;
  logic any_cond;
  logic raw;
  logic [15:0] target;

  // ****************************************
  // Condition match
  // ****************************************
  always_comb begin
    ok = '1;
    ok[`DBG_F_ADDR] = (core_bus_valid && core_addr == match_addr) ||
                      (core_pc_valid && core_pc == match_addr);
    ok[`DBG_F_DATA] = core_bus_valid && core_data == match_data;
    ok[`DBG_F_ASID] = core_asid == match_aux[7:0];
    ok[`DBG_F_BUS] = core_bus_valid && core_write == ctrl[`DBG_F_RW];
    ok[`DBG_F_WIN] = core_bus_valid && core_addr >= match_addr && core_addr <= match_data;
    ok[`DBG_F_SYS] = sys_valid && sys_addr == match_addr;
    ok[`DBG_F_TLB] = tlb_entry_load_instruction;
    ok[`DBG_F_BR] = core_branch;
    any_cond = |ctrl[`DBG_F_TLB:`DBG_F_ADDR] | ctrl[`DBG_F_BR];
    raw = ctrl[`DBG_F_EN] && any_cond && &(ok | ~ctrl[9:1] | 9'h080);
  end

  // ****************************************
  // Match counter
  // ****************************************
  always_comb begin
    target = (match_aux[31:16] == 16'h0000) ? 16'h0001 : match_aux[31:16];
    nxt_cnt = cnt_ff;
    hit = raw;
    if (ctrl[`DBG_F_CNT]) begin
      hit = 1'b0;
      if (raw) begin
        if (cnt_ff + 16'h0001 >= target) begin
          hit = 1'b1;
          nxt_cnt = 16'h0000;
        end else begin
          nxt_cnt = cnt_ff + 16'h0001;
        end
      end
    end
    if (clr_cnt) begin
      nxt_cnt = 16'h0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 16'h0000;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule : event_channel

// File: rtl/chain_sequencer.sv
// Ordered chaining of channel matches into one halt
`timescale 1ns/100ps
`include "dbg_defines.svh"
module chain_sequencer import dbg_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic clr,
  input seq_mode_t mode,
  input wire logic [`DBG_CH_NUM-1:0] hit,
  output logic fire,
  output logic [`DBG_CH_NUM-1:0] member,
  output logic [2:0] stage,
  output logic armed
);

  seq_state_t state_ff;
  seq_state_t nxt_state;
  logic [2:0] stage_ff;
  logic [2:0] nxt_stage;
  logic [35:0] plan;
  logic [3:0] len;
  logic [3:0] awaited;

  // Chain as channel indices, first stage in the low nibble
  function automatic logic [35:0] chain_of(input seq_mode_t m);
    case (m)
      SEQ_2_1: chain_of = {4'h2, 32'h0000_0001};
      SEQ_4_3: chain_of = {4'h2, 32'h0000_0023};
      SEQ_6_5: chain_of = {4'h2, 32'h0000_0045};
      SEQ_11_10: chain_of = {4'h2, 32'h0000_009a};
      SEQ_3_1: chain_of = {4'h3, 32'h0000_0012};
      SEQ_4_1: chain_of = {4'h4, 32'h0000_0123};
      SEQ_5_1: chain_of = {4'h5, 32'h0000_1234};
      SEQ_6_1: chain_of = {4'h6, 32'h0001_2345};
      SEQ_10_1: chain_of = {4'h7, 32'h0012_3459};
      SEQ_11_1: chain_of = {4'h8, 32'h0123_459a};
      default: chain_of = {4'h0, 32'h0000_0000};
    endcase
  endfunction : chain_of

  // ****************************************
  // Stage tracking
  // ****************************************
  always_comb begin
    plan = chain_of(mode);
    len = plan[35:32];
    awaited = 4'(plan[31:0] >> {stage_ff, 2'b00});
    member = '0;
    for (int i = 0; i < `DBG_STAGE_MAX; i++) begin
      if (4'(i) < len) begin
        member[plan[4*i +: 4]] = 1'b1;
      end
    end
    nxt_state = state_ff;
    nxt_stage = stage_ff;
    fire = 1'b0;
    case (state_ff)
      SEQ_IDLE: begin
        nxt_stage = 3'h0;
        if (len != 4'h0) begin
          nxt_state = SEQ_WAIT;
        end
      end
      SEQ_WAIT: begin
        if (len == 4'h0) begin
          nxt_state = SEQ_IDLE;
        end else if (hit[awaited]) begin
          if ({1'b0, stage_ff} == len - 4'h1) begin
            fire = 1'b1;
            nxt_stage = 3'h0;
          end else begin
            nxt_stage = stage_ff + 3'h1;
          end
        end
      end
      default: begin
        nxt_state = SEQ_IDLE;
      end
    endcase
    if (clr) begin
      nxt_state = SEQ_IDLE;
      nxt_stage = 3'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= SEQ_IDLE;
      stage_ff <= 3'h0;
    end else if (ce) begin
      state_ff <= nxt_state;
      stage_ff <= nxt_stage;
    end
  end

  assign stage = stage_ff;
  assign armed = state_ff == SEQ_WAIT;

endmodule : chain_sequencer

// File: rtl/debug_event_sequencer.sv
// Debug event sequencer top: APB registers, twelve channels, chaining, actions
//
// Contract
// - Twelve match channels plus software trace; each keeps only its own condition types.
// - Address match on 1-4,8-11; ASID on 1-6,10,11; system bus on 8,9.
// - Window range only on 5 and 6, which also offer trace.
// - Channel 7 matches only the TLB load instruction, action fixed to break.
// - 1-4,10,11 break/perf only; 5,6,8,9,12 break, trace and perf.
// - Count only on 2 and 11; branch only on 12; software trace fixed.
// - Chained channels produce a halt only after matching in defined order.
// - Pairs 2-1, 4-3, 6-5, 11-10 halt only first then second.
// - Descending chains from 3, 4, 5 or 6 down to channel 1.
// - Chains 10 then 6..1, and 11 then 10 then 6..1.
// - Address condition matches on address bus or program counter.
// - Count condition fires after the programmed number of matches.
// - Sequence state returns to start whenever the program breaks.
`timescale 1ns/100ps
`include "dbg_defines.svh"
module debug_event_sequencer import dbg_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`DBG_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic core_bus_valid,
  input wire logic core_write,
  input wire logic [31:0] core_addr,
  input wire logic [31:0] core_data,
  input wire logic core_pc_valid,
  input wire logic [31:0] core_pc,
  input wire logic [7:0] core_asid,
  input wire logic sys_valid,
  input wire logic [31:0] sys_addr,
  input wire logic tlb_entry_load_instruction,
  input wire logic core_branch,
  input wire logic sw_trace_exec,
  output logic break_req,
  output logic trace_req,
  output logic perf_start,
  output logic perf_stop
);

  localparam int NCH = `DBG_CH_NUM;

  logic [15:0] ctrl_ff [NCH];
  logic [15:0] nxt_ctrl [NCH];
  logic [31:0] addr_ff [NCH];
  logic [31:0] nxt_addr [NCH];
  logic [31:0] data_ff [NCH];
  logic [31:0] nxt_data [NCH];
  logic [31:0] aux_ff [NCH];
  logic [31:0] nxt_aux [NCH];
  seq_mode_t mode_ff;
  seq_mode_t nxt_mode;
  logic sw_en_ff;
  logic nxt_sw_en;
  logic [NCH-1:0] sticky_ff;
  logic [NCH-1:0] nxt_sticky;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic break_ff;
  logic nxt_break;
  logic trace_ff;
  logic nxt_trace;
  logic ps_ff;
  logic nxt_ps;
  logic pe_ff;
  logic nxt_pe;
  logic [NCH-1:0] hit;
  logic [NCH-1:0] member;
  logic [NCH-1:0] act_b;
  logic [NCH-1:0] act_t;
  logic [NCH-1:0] act_ps;
  logic [NCH-1:0] act_pe;
  logic seq_fire;
  logic seq_armed;
  logic [2:0] seq_stage;
  logic seq_clr;
  logic brk_evt;
  logic wr_go;
  logic [3:0] idx;
  logic [1:0] word;
  logic mapped;

  // Condition and action bits each channel may hold
  function automatic logic [15:0] cap_of(input int ch);
    case (ch)
      0: cap_of = `DBG_CAP_CH1;
      1: cap_of = `DBG_CAP_CH2;
      2: cap_of = `DBG_CAP_CH3;
      3: cap_of = `DBG_CAP_CH4;
      4: cap_of = `DBG_CAP_CH5;
      5: cap_of = `DBG_CAP_CH6;
      6: cap_of = `DBG_CAP_CH7;
      7: cap_of = `DBG_CAP_CH8;
      8: cap_of = `DBG_CAP_CH9;
      9: cap_of = `DBG_CAP_CH10;
      10: cap_of = `DBG_CAP_CH11;
      11: cap_of = `DBG_CAP_CH12;
      default: cap_of = 16'h0000;
    endcase
  endfunction : cap_of

  // Bits forced on whatever software writes
  function automatic logic [15:0] fix_of(input int ch);
    fix_of = (ch == 6) ? `DBG_FIX_CH7 : 16'h0000;
  endfunction : fix_of

  // Only listed chain modes are kept
  function automatic seq_mode_t mode_of(input logic [3:0] v);
    mode_of = (v > SEQ_11_1) ? SEQ_NONE : seq_mode_t'(v);
  endfunction : mode_of

  // ****************************************
  // APB decode
  // ****************************************
  always_comb begin
    idx = paddr[7:4];
    word = paddr[3:2];
    mapped = paddr[`DBG_ADDR_W-1:8] == '0 && paddr[1:0] == 2'b00 &&
             (idx < 4'(NCH) || (idx == `DBG_GLOBAL_IDX && word != 2'h3));
    wr_go = psel && penable && pready_ff && pwrite && mapped;
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      nxt_ctrl[i] = ctrl_ff[i];
      nxt_addr[i] = addr_ff[i];
      nxt_data[i] = data_ff[i];
      nxt_aux[i] = aux_ff[i];
      if (wr_go && idx == 4'(i)) begin
        case (word)
          `DBG_W_CTRL: nxt_ctrl[i] = (pwdata[15:0] & cap_of(i)) | fix_of(i);
          `DBG_W_ADDR: nxt_addr[i] = pwdata;
          `DBG_W_DATA: nxt_data[i] = pwdata;
          default: nxt_aux[i] = pwdata;
        endcase
      end
    end
    nxt_mode = mode_ff;
    nxt_sw_en = sw_en_ff;
    if (wr_go && idx == `DBG_GLOBAL_IDX && word == `DBG_W_SEQ) begin
      nxt_mode = mode_of(pwdata[3:0]);
    end
    if (wr_go && idx == `DBG_GLOBAL_IDX && word == `DBG_W_SWTR) begin
      nxt_sw_en = pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        ctrl_ff[i] <= `DBG_RST_CTRL | fix_of(i);
        addr_ff[i] <= `DBG_RST_WORD;
        data_ff[i] <= `DBG_RST_WORD;
        aux_ff[i] <= `DBG_RST_WORD;
      end
      mode_ff <= SEQ_NONE;
      sw_en_ff <= 1'b0;
    end else if (ce) begin
      for (int i = 0; i < NCH; i++) begin
        ctrl_ff[i] <= nxt_ctrl[i];
        addr_ff[i] <= nxt_addr[i];
        data_ff[i] <= nxt_data[i];
        aux_ff[i] <= nxt_aux[i];
      end
      mode_ff <= nxt_mode;
      sw_en_ff <= nxt_sw_en;
    end
  end

  // ****************************************
  // APB answer
  // ****************************************
  always_comb begin
    nxt_pready = psel && !penable;
    nxt_pslverr = psel && !penable && !mapped;
    nxt_prdata = 32'h0000_0000;
    if (psel && !penable && !pwrite && mapped) begin
      if (idx == `DBG_GLOBAL_IDX) begin
        case (word)
          `DBG_W_SEQ: nxt_prdata = {28'h0000000, mode_ff};
          `DBG_W_STATUS: nxt_prdata = {12'h000, seq_armed, seq_stage, 4'h0, sticky_ff};
          default: nxt_prdata = {31'h00000000, sw_en_ff};
        endcase
      end else begin
        for (int i = 0; i < NCH; i++) begin
          if (idx == 4'(i)) begin
            case (word)
              `DBG_W_CTRL: nxt_prdata = {16'h0000, ctrl_ff[i]};
              `DBG_W_ADDR: nxt_prdata = addr_ff[i];
              `DBG_W_DATA: nxt_prdata = data_ff[i];
              default: nxt_prdata = aux_ff[i];
            endcase
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (ce) begin
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // ****************************************
  // Match channels
  // ****************************************
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    event_channel u_ch (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .clr_cnt(wr_go && idx == 4'(g)),
      .ctrl(ctrl_ff[g]),
      .match_addr(addr_ff[g]),
      .match_data(data_ff[g]),
      .match_aux(aux_ff[g]),
      .core_bus_valid(core_bus_valid),
      .core_write(core_write),
      .core_addr(core_addr),
      .core_data(core_data),
      .core_pc_valid(core_pc_valid),
      .core_pc(core_pc),
      .core_asid(core_asid),
      .sys_valid(sys_valid),
      .sys_addr(sys_addr),
      .tlb_entry_load_instruction(tlb_entry_load_instruction),
      .core_branch(core_branch),
      .hit(hit[g])
    );
    assign act_b[g] = ctrl_ff[g][`DBG_F_ACT_B];
    assign act_t[g] = ctrl_ff[g][`DBG_F_ACT_T];
    assign act_ps[g] = ctrl_ff[g][`DBG_F_ACT_PS];
    assign act_pe[g] = ctrl_ff[g][`DBG_F_ACT_PE];
  end

  // ****************************************
  // Chain sequencer
  // ****************************************
  assign seq_clr = break_ff || (wr_go && idx == `DBG_GLOBAL_IDX && word == `DBG_W_SEQ);

  chain_sequencer u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .clr(seq_clr),
    .mode(mode_ff),
    .hit(hit),
    .fire(seq_fire),
    .member(member),
    .stage(seq_stage),
    .armed(seq_armed)
  );

  // ****************************************
  // Actions and status
  // ****************************************
  always_comb begin
    brk_evt = |(hit & act_b & ~member) || seq_fire;
    nxt_break = brk_evt;
    nxt_trace = |(hit & act_t) || (sw_trace_exec && sw_en_ff);
    nxt_ps = |(hit & act_ps);
    nxt_pe = |(hit & act_pe);
    nxt_sticky = sticky_ff;
    if (wr_go && idx == `DBG_GLOBAL_IDX && word == `DBG_W_STATUS) begin
      nxt_sticky = sticky_ff & ~pwdata[NCH-1:0];
    end
    nxt_sticky = nxt_sticky | hit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_ff <= 1'b0;
      trace_ff <= 1'b0;
      ps_ff <= 1'b0;
      pe_ff <= 1'b0;
      sticky_ff <= '0;
    end else if (ce) begin
      break_ff <= nxt_break;
      trace_ff <= nxt_trace;
      ps_ff <= nxt_ps;
      pe_ff <= nxt_pe;
      sticky_ff <= nxt_sticky;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign break_req = break_ff;
  assign trace_req = trace_ff;
  assign perf_start = ps_ff;
  assign perf_stop = pe_ff;

endmodule : debug_event_sequencer

// File: verif/debug_event_sequencer_monitor.sv
// Port-level checker for the debug event sequencer
`timescale 1ns/100ps
module debug_event_sequencer_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tlb_entry_load_instruction,
  input wire logic sw_trace_exec,
  input wire logic break_req,
  input wire logic trace_req
);
  // ****************************************
  // Shadow of a few configuration bits
  // ****************************************
  logic wr_hit;
  logic swtr_ff;
  logic nxt_swtr;
  logic tlb_on_ff;
  logic nxt_tlb_on;

  assign wr_hit = ce && psel && penable && pready && pwrite;

  always_comb begin
    nxt_swtr = swtr_ff;
    nxt_tlb_on = tlb_on_ff;
    if (wr_hit && paddr == 12'h0c8) begin
      nxt_swtr = pwdata[0];
    end
    if (wr_hit && paddr == 12'h060) begin
      nxt_tlb_on = pwdata[0] && pwdata[7];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swtr_ff <= 1'b0;
      tlb_on_ff <= 1'b0;
    end else begin
      swtr_ff <= nxt_swtr;
      tlb_on_ff <= nxt_tlb_on;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  apb_answer_a: assert property (psel && !penable && ce |=> pready)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready && ce |=> !pready)
    else $error("answer longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without answer");
  unmapped_err_a: assert property (psel && !penable && ce && paddr[11:8] != 4'h0
    |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  mapped_ok_a: assert property (psel && !penable && ce && paddr == 12'h0c0
    |=> pready && !pslverr) else $error("mode register refused");
  sw_trace_a: assert property (ce && sw_trace_exec && swtr_ff |=> trace_req)
    else $error("software trace not issued");
  tlb_break_a: assert property (ce && tlb_entry_load_instruction && tlb_on_ff
    |=> break_req) else $error("tlb load did not break");
  freeze_a: assert property (!ce |=> $stable(break_req) && $stable(pready))
    else $error("state moved while frozen");
endmodule : debug_event_sequencer_monitor

bind debug_event_sequencer debug_event_sequencer_monitor i_mon (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .tlb_entry_load_instruction(tlb_entry_load_instruction),
  .sw_trace_exec(sw_trace_exec), .break_req(break_req), .trace_req(trace_req)
);

// File: verif/debug_host.sv
// Debugger-side APB master that programs the event channels
`timescale 1ns/100ps
module debug_host (
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end

  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer

  task automatic write(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask : write

  task automatic read(input logic [11:0] a, output logic [31:0] q, output logic e);
    xfer(1'b0, a, 32'h0, q, e);
  endtask : read
endmodule : debug_host

// File: verif/tb.sv
// Self-checking bench for the debug event sequencer
`timescale 1ns/100ps
module tb;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, ev_addr;
  logic ev_v, tlb, sw_tr, break_req, trace_req, perf_start, perf_stop, ps_seen, pe_seen;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [15:0] caps [12] = '{16'h741b, 16'h751f, 16'h340b, 16'h340b, 16'h7c39, 16'h7c39,
                             16'h0481, 16'h3c43, 16'h3c43, 16'h741b, 16'h751f, 16'h3e01};
  logic [35:0] seqs [11] = '{36'h0, 36'h21, 36'h43, 36'h65, 36'hba, 36'h321, 36'h4321,
                             36'h54321, 36'h654321, 36'ha654321, 36'hba654321};

  debug_host i_host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  debug_event_sequencer i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_bus_valid(ev_v), .core_write(1'b0),
    .core_addr(ev_addr), .core_data(32'h0), .core_pc_valid(ev_v), .core_pc(ev_addr),
    .core_asid(8'h0), .sys_valid(ev_v), .sys_addr(ev_addr),
    .tlb_entry_load_instruction(tlb), .core_branch(1'b0), .sw_trace_exec(sw_tr),
    .break_req(break_req), .trace_req(trace_req), .perf_start(perf_start),
    .perf_stop(perf_stop));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  // ****************************************
  // Helpers
  // ****************************************
  task automatic hit(input int ch, output logic brk);
    @(posedge pclk);
    ev_v <= 1'b1;
    ev_addr <= 32'h1000 + 32'(ch) * 32'h10;
    @(posedge pclk);
    ev_v <= 1'b0;
    ev_addr <= 32'hffff_ffff;
    @(negedge pclk);
    brk = break_req;
    ps_seen = perf_start;
    pe_seen = perf_stop;
    @(posedge pclk);
  endtask : hit

  task automatic cfg(input int ch, input logic [31:0] ctrl);
    logic [11:0] b;
    b = 12'((ch - 1) * 16);
    i_host.write(b, ctrl);
    i_host.write(b + 12'h4, 32'h1000 + 32'(ch) * 32'h10);
    i_host.write(b + 12'h8, 32'h1000 + 32'(ch) * 32'h10);
  endtask : cfg

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_caps;
    logic [31:0] d;
    logic e;
    i_host.read(12'h060, d, e);
    check("ch7 ctrl reset", d, 32'h0400);
    for (int c = 0; c < 12; c++) begin
      i_host.write(12'(c * 16), 32'h0000_ffff);
      i_host.read(12'(c * 16), d, e);
      check("ctrl mask", d, {16'h0, caps[c]});
      i_host.write(12'(c * 16), 32'h0);
    end
    i_host.read(12'h0d0, d, e);
    check("unmapped data", d, 32'h0);
    check("unmapped err", 32'(e), 32'h1);
    i_host.read(12'h100, d, e);
    check("high addr err", 32'(e), 32'h1);
  endtask : t_caps

  task automatic t_chains;
    logic b;
    logic [35:0] s;
    int n;
    for (int c = 1; c <= 11; c++) begin
      if (c < 7 || c > 9) begin
        cfg(c, (c == 5 || c == 6) ? 32'h0421 : 32'h0403);
      end
    end
    for (int md = 1; md <= 10; md++) begin
      s = seqs[md];
      i_host.write(12'h0c0, 32'(md));
      repeat (3) @(posedge pclk);
      hit(int'(s[3:0]), b);
      check("early final", 32'(b), 32'h0);
      for (int k = 8; k >= 0; k--) begin
        n = int'(s[k*4 +: 4]);
        if (n != 0) begin
          hit(n, b);
          check("chain step", 32'(b), 32'(k == 0));
        end
      end
      hit(int'(s[3:0]), b);
      check("after halt", 32'(b), 32'h0);
    end
  endtask : t_chains

  task automatic t_single;
    logic b;
    logic [31:0] d;
    logic e;
    i_host.write(12'h0c0, 32'h0000_000f);
    i_host.read(12'h0c0, d, e);
    check("mode clamp", d, 32'h0);
    cfg(2, 32'h0503);
    i_host.write(12'h01c, 32'h0003_0000);
    for (int i = 1; i <= 3; i++) begin
      hit(2, b);
      check("count", 32'(b), 32'(i == 3));
    end
    hit(1, b);
    check("single break", 32'(b), 32'h1);
    i_host.write(12'h060, 32'h0000_0081);
    i_host.write(12'h0c8, 32'h1);
    @(posedge pclk);
    tlb <= 1'b1;
    sw_tr <= 1'b1;
    @(posedge pclk);
    tlb <= 1'b0;
    sw_tr <= 1'b0;
    @(negedge pclk);
    check("tlb break", 32'(break_req), 32'h1);
    check("sw trace", 32'(trace_req), 32'h1);
    @(posedge pclk);
    ce <= 1'b0;
    hit(1, b);
    ce <= 1'b1;
    check("frozen", 32'(b), 32'h0);
    i_host.write(12'h020, 32'h0000_2003);
    i_host.write(12'h030, 32'h0000_1003);
    i_host.write(12'h0c4, 32'h0000_0fff);
    hit(3, b);
    check("perf stop", 32'(pe_seen), 32'h1);
    hit(4, b);
    check("perf start", 32'(ps_seen), 32'h1);
    i_host.read(12'h0c4, d, e);
    check("sticky hits", d, 32'h0000_000c);
  endtask : t_single

  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    ev_v = 1'b0;
    ev_addr = 32'h0;
    tlb = 1'b0;
    sw_tr = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_caps();
    t_chains();
    t_single();
    close_out();
  end
endmodule : tb
